/* logic/adc_serial_out.sv */
`timescale 1ns/1ns
module adc_serial_out (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        ENC_CLK,
  input  wire logic        CONFIG_INTERFACE_SELECT,
  input  wire logic        LANE_SEL_PIN,
  input  wire logic        CURRENT_SEL_PIN,
  input  wire logic        SLEEP_PIN,
  input  wire logic        TERM_PIN,
  input  wire logic [55:0] CONV_RESULT,
  output logic      [3:0]  DATA_OUT_A,
  output logic      [3:0]  DATA_OUT_B,
  output logic             DATA_CLOCK_OUT,
  output logic             FRAME_MARKER,
  output logic             OUT_DRIVE_EN,
  output logic      [7:0]  DRIVE_CURRENT,
  output logic             CORE_SLEEP,
  output logic      [3:0]  CHANNEL_NAP
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0] pins_sync;
  logic       enc_s;
  logic       par_s;
  logic       lane_pin_s;
  logic       cur_pin_s;
  logic       sleep_pin_s;
  logic       term_pin_s;

  pin_sync #(.W(6)) u_sync (
    .clk (CLK),
    .rst (SYS_RST),
    .d   ({ENC_CLK, CONFIG_INTERFACE_SELECT, LANE_SEL_PIN,
           CURRENT_SEL_PIN, SLEEP_PIN, TERM_PIN}),
    .q   (pins_sync)
  );

  assign {enc_s, par_s, lane_pin_s, cur_pin_s, sleep_pin_s, term_pin_s} = pins_sync;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0]  pd_reg;
  logic [7:0]  oc_reg;
  logic [15:0] tp_reg;
  logic [31:0] rdata_reg;
  logic        ack_reg;
  logic        wb_req;
  logic        wb_wr;
  logic        sel_pd;
  logic        sel_oc;
  logic        sel_tp;
  logic        sel_st;
  logic [31:0] rd_mux;
  logic [15:0] status_word;

  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign wb_wr  = wb_req & WB_WE_I;
  assign sel_pd = WB_ADR_I == adc_out_pkg::ADDR_POWER_DOWN;
  assign sel_oc = WB_ADR_I == adc_out_pkg::ADDR_OUTPUT_CTRL;
  assign sel_tp = WB_ADR_I == adc_out_pkg::ADDR_TEST_PAT;
  assign sel_st = WB_ADR_I == adc_out_pkg::ADDR_STATUS;
  // Unmapped addresses are acknowledged and read as zero
  assign rd_mux = sel_pd ? {24'h000000, pd_reg} :
                  sel_oc ? {24'h000000, oc_reg} :
                  sel_tp ? {16'h0000, tp_reg} :
                  sel_st ? {16'h0000, status_word} : 32'h00000000;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pd_reg    <= adc_out_pkg::POWER_DOWN_RST;
      oc_reg    <= adc_out_pkg::OUTPUT_CTRL_RST;
      tp_reg    <= adc_out_pkg::TEST_PAT_RST;
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= wb_req;
      if (wb_req) begin
        rdata_reg <= rd_mux;
      end
      if (wb_wr && sel_pd && WB_SEL_I[0]) begin
        pd_reg <= WB_DAT_I[7:0];
      end
      if (wb_wr && sel_oc && WB_SEL_I[0]) begin
        oc_reg <= WB_DAT_I[7:0];
      end
      if (wb_wr && sel_tp && WB_SEL_I[0]) begin
        tp_reg[7:0] <= WB_DAT_I[7:0];
      end
      if (wb_wr && sel_tp && WB_SEL_I[1]) begin
        tp_reg[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;

  // ----------------------------------------
  // Effective configuration
  // ----------------------------------------
  // Parallel mode reaches only lanes, current, sleep and termination;
  // format, randomizer, test pattern and nap fall back to their defaults.
  adc_out_pkg::cfg_t cfg;

  assign cfg.lanes1   = par_s ? lane_pin_s
                              : oc_reg[adc_out_pkg::OC_LANE1_BIT];
  assign cfg.wlen     = par_s ? (lane_pin_s ? adc_out_pkg::WLEN_14 : adc_out_pkg::WLEN_16)
                              : oc_reg[adc_out_pkg::OC_WLEN_LSB +: 2];
  assign cfg.twos     = ~par_s & pd_reg[adc_out_pkg::PD_TWOS_BIT];
  assign cfg.randomizer_enable_en  = ~par_s & pd_reg[adc_out_pkg::PD_RANDOMIZER_ENABLE_BIT];
  assign cfg.test_en  = ~par_s & tp_reg[adc_out_pkg::TP_EN_BIT];
  assign cfg.test_pat = tp_reg[13:0];
  assign cfg.nap      = par_s ? 4'h0 : pd_reg[adc_out_pkg::PD_NAP_LSB +: 4];
  assign cfg.sleep    = par_s ? sleep_pin_s
                              : pd_reg[adc_out_pkg::PD_SLEEP_BIT];
  assign cfg.out_off  = ~par_s & oc_reg[adc_out_pkg::OC_OFF_BIT];
  assign cfg.term     = par_s ? term_pin_s
                              : oc_reg[adc_out_pkg::OC_TERM_BIT];
  assign cfg.cur_code = par_s ? (cur_pin_s ? adc_out_pkg::CODE_1P75
                                           : adc_out_pkg::CODE_3P5)
                              : oc_reg[adc_out_pkg::OC_CUR_LSB +: 3];

  // ----------------------------------------
  // Driver current
  // ----------------------------------------
  logic [7:0] cur_base;
  logic [7:0] cur_eff;

  // Reserved code 7 falls back to the default level
  assign cur_base = (cfg.cur_code == 3'h0) ? adc_out_pkg::CUR_1P75 :
                    (cfg.cur_code == 3'h1) ? adc_out_pkg::CUR_2P1  :
                    (cfg.cur_code == 3'h2) ? adc_out_pkg::CUR_2P5  :
                    (cfg.cur_code == 3'h3) ? adc_out_pkg::CUR_3P0  :
                    (cfg.cur_code == 3'h5) ? adc_out_pkg::CUR_4P0  :
                    (cfg.cur_code == 3'h6) ? adc_out_pkg::CUR_4P5  :
                                             adc_out_pkg::CUR_3P5;
  // Doubling keeps the swing with the extra internal load
  assign cur_eff  = cfg.term ? {cur_base[6:0], 1'b0} : cur_base;

  // ----------------------------------------
  // Sample formatting
  // ----------------------------------------
  adc_out_pkg::fmt_t fmt;
  logic [15:0]       words [adc_out_pkg::NCH];

  assign fmt.pattern = cfg.test_pat;
  assign fmt.test_en = cfg.test_en;
  assign fmt.twos    = cfg.twos;
  assign fmt.randomizer_enable_en = cfg.randomizer_enable_en;

  genvar c;
  generate
    for (c = 0; c < adc_out_pkg::NCH; c++) begin : g_fmt
      sample_formatter u_fmt (
        .raw  (CONV_RESULT[c*14 +: 14]),
        .fmt  (fmt),
        .word (words[c])
      );
    end
  endgenerate

  // ----------------------------------------
  // Serializer
  // ----------------------------------------
  // One bit period per CLK cycle; the word is sent as a burst after each
  // encode edge, so the encode period must cover the bit periods.
  logic       enc_d_reg;
  logic       enc_rise;
  logic [4:0] wbits;
  logic [4:0] nbits;
  logic [4:0] half;
  logic       half_mode;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [4:0] n_reg;
  logic       lanes1_reg;
  logic       half_mode_reg;
  logic       emit;
  logic       frame_reg;
  logic       frame_next;
  logic       dco_reg;
  logic [15:0] sh_reg [adc_out_pkg::NCH];
  logic [3:0] bit_a;
  logic [3:0] bit_b;
  logic       drive_on;
  logic       bit_step;
  logic       dco_next;
  logic       frame_now;

  assign enc_rise  = enc_s & ~enc_d_reg;
  assign wbits     = (cfg.wlen == adc_out_pkg::WLEN_14) ? 5'hE :
                     (cfg.wlen == adc_out_pkg::WLEN_12) ? 5'hC : 5'h10;
  assign nbits     = cfg.lanes1 ? wbits : {1'b0, wbits[4:1]};
  assign half_mode = ~cfg.lanes1 & (cfg.wlen == adc_out_pkg::WLEN_14);
  assign half      = {1'b0, n_reg[4:1]};
  assign emit      = (cnt_reg != 5'h0) & ~cfg.sleep;
  assign cnt_next  = cnt_reg - 5'h1;
  assign drive_on  = ~cfg.out_off & ~cfg.sleep;
  // Lanes, clock and frame move on the same step, so the receiver sees aligned edges
  assign bit_step  = emit & ~enc_rise;
  assign dco_next  = bit_step ? ~dco_reg : dco_reg;
  assign frame_now = bit_step ? frame_next : frame_reg;

  // Frame: toggles per word in 2-lane 14-bit, else high for the first half
  assign frame_next = half_mode_reg ? ((cnt_reg == n_reg) ? ~frame_reg : frame_reg)
                                    : (cnt_reg > half);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      enc_d_reg     <= 1'b0;
      cnt_reg       <= 5'h0;
      n_reg         <= 5'h0;
      lanes1_reg    <= 1'b0;
      half_mode_reg <= 1'b0;
      frame_reg     <= 1'b0;
      dco_reg       <= 1'b0;
    end else begin
      enc_d_reg <= enc_s;
      if (cfg.sleep) begin
        cnt_reg <= 5'h0;
      end else if (enc_rise) begin
        // A new sample restarts the burst even if the last one is unfinished
        cnt_reg       <= nbits;
        n_reg         <= nbits;
        lanes1_reg    <= cfg.lanes1;
        half_mode_reg <= half_mode;
      end else if (emit) begin
        cnt_reg   <= cnt_next;
        frame_reg <= frame_next;
        dco_reg   <= ~dco_reg;
      end
    end
  end

  generate
    for (c = 0; c < adc_out_pkg::NCH; c++) begin : g_lane
      assign bit_a[c] = sh_reg[c][15];
      assign bit_b[c] = lanes1_reg ? 1'b0 : sh_reg[c][14];
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          sh_reg[c] <= 16'h0000;
        end else if (enc_rise && !cfg.sleep) begin
          sh_reg[c] <= words[c];
        end else if (emit) begin
          sh_reg[c] <= lanes1_reg ? {sh_reg[c][14:0], 1'b0}
                                  : {sh_reg[c][13:0], 2'h0};
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      DATA_OUT_A     <= 4'h0;
      DATA_OUT_B     <= 4'h0;
      DATA_CLOCK_OUT <= 1'b0;
      FRAME_MARKER   <= 1'b0;
      OUT_DRIVE_EN   <= 1'b0;
      DRIVE_CURRENT  <= 8'h00;
      CORE_SLEEP     <= 1'b0;
      CHANNEL_NAP    <= 4'h0;
    end else begin
      if (!drive_on) begin
        DATA_OUT_A <= 4'h0;
        DATA_OUT_B <= 4'h0;
      end else if (bit_step) begin
        DATA_OUT_A <= bit_a & ~cfg.nap;
        DATA_OUT_B <= bit_b & ~cfg.nap;
      end else begin
        // A channel put to nap between bursts goes quiet at once
        DATA_OUT_A <= DATA_OUT_A & ~cfg.nap;
        DATA_OUT_B <= DATA_OUT_B & ~cfg.nap;
      end
      DATA_CLOCK_OUT <= drive_on & dco_next;
      FRAME_MARKER   <= drive_on & frame_now;
      OUT_DRIVE_EN   <= drive_on;
      DRIVE_CURRENT  <= drive_on ? cur_eff : 8'h00;
      CORE_SLEEP     <= cfg.sleep;
      CHANNEL_NAP    <= cfg.nap;
    end
  end

  assign status_word = {cur_eff, 3'h0, frame_reg, emit, cfg.lanes1, cfg.wlen};

endmodule

/* logic/adc_out_pkg.sv */
// What this block does
// - Two lanes or one lane per channel
// - 16, 14, 12-bit words; 12 drops LSBs
// - Frame marks word start; halved in 2-lane 14
// - Clock toggles once per bit period
// - Drive current default 3.5mA, seven selectable
// - Parallel mode: current pin picks 3.5/1.75mA
// - Termination enabled doubles the drive current
// - Termination from register or parallel pin
// - Offset binary default, two's complement selectable
// - Two's complement inverts the MSB
// - Randomizer XORs upper bits with LSB
// - Randomizer leaves clock and frame alone
// - Test pattern overrides format and randomizer
// - Output disable turns off every output pair
// - Sleep from register bit or parallel pin
// - Per-channel nap from register only
// - Power-down register bit layout
// - Parallel lane pin picks 2-lane16 or 1-lane14
package adc_out_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] ADDR_POWER_DOWN  = 4'h0;
  localparam logic [3:0] ADDR_OUTPUT_CTRL = 4'h4;
  localparam logic [3:0] ADDR_TEST_PAT    = 4'h8;
  localparam logic [3:0] ADDR_STATUS      = 4'hC;

  // Power-down register fields
  localparam int PD_RANDOMIZER_ENABLE_BIT  = 6;
  localparam int PD_TWOS_BIT  = 5;
  localparam int PD_SLEEP_BIT = 4;
  localparam int PD_NAP_LSB   = 0;

  // Output control register fields
  localparam int OC_CUR_LSB   = 0;
  localparam int OC_TERM_BIT  = 3;
  localparam int OC_OFF_BIT   = 4;
  localparam int OC_LANE1_BIT = 5;
  localparam int OC_WLEN_LSB  = 6;

  // Test pattern register fields
  localparam int TP_EN_BIT    = 15;

  // Reset values
  localparam logic [7:0]  POWER_DOWN_RST  = 8'h00;
  localparam logic [7:0]  OUTPUT_CTRL_RST = 8'h04;
  localparam logic [15:0] TEST_PAT_RST    = 16'h0000;

  // ----------------------------------------
  // Modes and driver current
  // ----------------------------------------
  localparam logic [1:0] WLEN_16 = 2'h0;
  localparam logic [1:0] WLEN_14 = 2'h1;
  localparam logic [1:0] WLEN_12 = 2'h2;

  // Current in units of 50 uA, indexed by code 0..6
  localparam logic [7:0] CUR_1P75 = 8'h23;
  localparam logic [7:0] CUR_2P1  = 8'h2A;
  localparam logic [7:0] CUR_2P5  = 8'h32;
  localparam logic [7:0] CUR_3P0  = 8'h3C;
  localparam logic [7:0] CUR_3P5  = 8'h46;
  localparam logic [7:0] CUR_4P0  = 8'h50;
  localparam logic [7:0] CUR_4P5  = 8'h5A;
  localparam logic [2:0] CODE_1P75 = 3'h0;
  localparam logic [2:0] CODE_3P5  = 3'h4;

  localparam int NCH = 4;

  typedef struct packed {
    logic        lanes1;
    logic [1:0]  wlen;
    logic        twos;
    logic        randomizer_enable_en;
    logic        test_en;
    logic [13:0] test_pat;
    logic [3:0]  nap;
    logic        sleep;
    logic        out_off;
    logic        term;
    logic [2:0]  cur_code;
  } cfg_t;

  typedef struct packed {
    logic [13:0] pattern;
    logic        test_en;
    logic        twos;
    logic        randomizer_enable_en;
  } fmt_t;

endpackage

/* logic/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      // A change is accepted only when the second and third stages agree
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          q[i]   <= 1'b0;
        end else begin
          s1_reg <= d[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q[i] <= s3_reg;
          end
        end
      end
    end
  endgenerate

endmodule

/* logic/sample_formatter.sv */
`timescale 1ns/1ns
module sample_formatter (
  input  wire logic [13:0]         raw,
  input  wire adc_out_pkg::fmt_t   fmt,
  output logic      [15:0]         word
);

  logic [13:0] coded;
  logic [13:0] mixed;
  logic [13:0] chosen;

  assign coded  = {raw[13] ^ fmt.twos, raw[12:0]};
  assign mixed  = fmt.randomizer_enable_en ? {coded[13:1] ^ {13{coded[0]}}, coded[0]}
                              : coded;
  assign chosen = fmt.test_en ? fmt.pattern : mixed;
  // Left aligned; short words simply stop early, so 12-bit drops the LSBs
  assign word   = {chosen, 2'h0};

endmodule

/* verification/adc_serial_out_sva.sv */
`timescale 1ns/1ns
module adc_serial_out_sva (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       WB_CYC_I,
  input wire logic       WB_STB_I,
  input wire logic       WB_ACK_O,
  input wire logic [3:0] DATA_OUT_A,
  input wire logic [3:0] DATA_OUT_B,
  input wire logic       DATA_CLOCK_OUT,
  input wire logic       FRAME_MARKER,
  input wire logic       OUT_DRIVE_EN,
  input wire logic [7:0] DRIVE_CURRENT,
  input wire logic       CORE_SLEEP,
  input wire logic [3:0] CHANNEL_NAP
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence req_taken; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence ack_once; WB_ACK_O ##1 !WB_ACK_O; endsequence
  sequence drivers_off; (!OUT_DRIVE_EN) [*3]; endsequence
  sequence asleep; CORE_SLEEP [*3]; endsequence
  // Output pairs settle a cycle after a mode change, so the quiet window excludes it
  sequence steady;
    OUT_DRIVE_EN && $past(OUT_DRIVE_EN) && !CORE_SLEEP && !$past(CORE_SLEEP)
      && CHANNEL_NAP == $past(CHANNEL_NAP) && CHANNEL_NAP == $past(CHANNEL_NAP, 2);
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  ack_answer_a: assert property (req_taken |=> ack_once)
    else $error("ack not a single pulse one cycle after a request");
  ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without a request");
  off_quiet_a: assert property (drivers_off |-> DRIVE_CURRENT == 8'h00
    && !DATA_CLOCK_OUT && !FRAME_MARKER && (DATA_OUT_A | DATA_OUT_B) == 4'h0)
    else $error("outputs active while disabled");
  sleep_quiet_a: assert property (asleep |-> !DATA_CLOCK_OUT && !FRAME_MARKER
    && (DATA_OUT_A | DATA_OUT_B) == 4'h0) else $error("outputs active in sleep");
  nap_quiet_a: assert property ((CHANNEL_NAP & $past(CHANNEL_NAP) & $past(CHANNEL_NAP, 2)
    & (DATA_OUT_A | DATA_OUT_B)) == 4'h0) else $error("napped channel lane active");
  frame_on_bit_a: assert property ($changed(FRAME_MARKER) ##0 steady
    |-> $changed(DATA_CLOCK_OUT)) else $error("frame moved off a bit boundary");
  data_on_bit_a: assert property ($changed(DATA_OUT_A) ##0 steady
    |-> $changed(DATA_CLOCK_OUT)) else $error("lane moved without data clock");
  current_legal_a: assert property (OUT_DRIVE_EN |-> DRIVE_CURRENT inside
    {8'h23, 8'h2A, 8'h32, 8'h3C, 8'h46, 8'h50, 8'h5A, 8'h54, 8'h64, 8'h78, 8'h8C, 8'hA0,
     8'hB4}) else $error("drive current not a legal level");
endmodule

bind adc_serial_out adc_serial_out_sva i_adc_serial_out_sva (.CLK(CLK), .SYS_RST(SYS_RST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .DATA_OUT_A(DATA_OUT_A),
  .DATA_OUT_B(DATA_OUT_B), .DATA_CLOCK_OUT(DATA_CLOCK_OUT), .FRAME_MARKER(FRAME_MARKER),
  .OUT_DRIVE_EN(OUT_DRIVE_EN), .DRIVE_CURRENT(DRIVE_CURRENT), .CORE_SLEEP(CORE_SLEEP),
  .CHANNEL_NAP(CHANNEL_NAP));

/* verification/lvds_receiver.sv */
`timescale 1ns/1ns
module lvds_receiver (
  input  wire logic        clk,
  input  wire logic [3:0]  lane_a,
  input  wire logic [3:0]  lane_b,
  input  wire logic        data_clock_out,
  input  wire logic        frame,
  input  wire logic        one_lane,
  input  wire logic [4:0]  bits,
  input  wire logic        randomizer_enable_en,
  output logic      [15:0] word [4],
  output logic      [13:0] clean [4],
  output logic             done
);
  logic [15:0] sh [4];
  logic        dco_q = 1'b0;
  logic        frame_q = 1'b0;
  int          cnt = 99;
  // Bits are taken on every change of the data clock, rising or falling
  always @(posedge clk) begin
    done <= 1'b0;
    if (data_clock_out !== dco_q) begin
      if ((frame && !frame_q) || (!one_lane && bits == 14 && frame !== frame_q)) cnt = 0;
      for (int c = 0; c < 4; c++)
        sh[c] = one_lane ? {sh[c][14:0], lane_a[c]} : {sh[c][13:0], lane_a[c], lane_b[c]};
      cnt++;
      if (cnt == (one_lane ? bits : bits / 2)) begin
        for (int c = 0; c < 4; c++) word[c] <= sh[c] << (16 - bits);
        done <= 1'b1;
      end
    end
    dco_q = data_clock_out;
    frame_q = frame;
  end
  always_comb begin
    for (int c = 0; c < 4; c++)
      clean[c] = word[c][15:2] ^ (randomizer_enable_en ? {{13{word[c][2]}}, 1'b0} : 14'h0000);
  end
endmodule

/* verification/adc_serial_out_tb.sv */
`timescale 1ns/1ns
module adc_serial_out_tb;
  logic        CLK, SYS_RST, WB_CYC_I, WB_STB_I, WB_WE_I, ENC_CLK, done;
  logic        CONFIG_INTERFACE_SELECT, LANE_SEL_PIN, CURRENT_SEL_PIN, SLEEP_PIN, TERM_PIN;
  logic        WB_ACK_O, DATA_CLOCK_OUT, FRAME_MARKER, OUT_DRIVE_EN, CORE_SLEEP;
  logic [3:0]  WB_ADR_I, WB_SEL_I, DATA_OUT_A, DATA_OUT_B, CHANNEL_NAP, nap;
  logic [31:0] WB_DAT_I, WB_DAT_O, rd;
  logic [55:0] CONV_RESULT;
  logic [7:0]  DRIVE_CURRENT;
  logic [15:0] word [4];
  logic [13:0] clean [4];
  logic [13:0] pat;
  logic [15:0] lfsr_q = 16'h0032;
  logic        one_lane, twos, rnd, tst;
  logic [4:0]  bits;
  int          fail_count = 0;
  int          comparisons = 0;

  adc_serial_out i_adc_serial_out (.CLK(CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ENC_CLK(ENC_CLK),
    .CONFIG_INTERFACE_SELECT(CONFIG_INTERFACE_SELECT), .LANE_SEL_PIN(LANE_SEL_PIN),
    .CURRENT_SEL_PIN(CURRENT_SEL_PIN), .SLEEP_PIN(SLEEP_PIN), .TERM_PIN(TERM_PIN),
    .CONV_RESULT(CONV_RESULT), .DATA_OUT_A(DATA_OUT_A), .DATA_OUT_B(DATA_OUT_B),
    .DATA_CLOCK_OUT(DATA_CLOCK_OUT), .FRAME_MARKER(FRAME_MARKER), .OUT_DRIVE_EN(OUT_DRIVE_EN),
    .DRIVE_CURRENT(DRIVE_CURRENT), .CORE_SLEEP(CORE_SLEEP), .CHANNEL_NAP(CHANNEL_NAP));
  lvds_receiver i_lvds_receiver (.clk(CLK), .lane_a(DATA_OUT_A), .lane_b(DATA_OUT_B),
    .data_clock_out(DATA_CLOCK_OUT), .frame(FRAME_MARKER), .one_lane(one_lane), .bits(bits),
    .randomizer_enable_en(rnd && !tst), .word(word), .clean(clean), .done(done));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] exp_word(input logic [13:0] d, input int c);
    logic [13:0] v;
    v = twos ? d ^ 14'h2000 : d;
    if (rnd) v = v ^ {{13{v[0]}}, 1'b0};
    if (tst) v = pat;
    if (nap[c]) v = 14'h0000;
    exp_word = {v, 2'b00} & (16'hFFFF << (16 - bits));
  endfunction
  function automatic logic [7:0] cur_of(input logic [3:0] k);
    logic [7:0] t [8] = '{8'h23, 8'h2A, 8'h32, 8'h3C, 8'h46, 8'h50, 8'h5A, 8'h46};
    cur_of = t[k[2:0]] << k[3];
  endfunction
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= adr;
    WB_DAT_I <= dat;
    do begin
      @(posedge CLK);
    end while (WB_ACK_O !== 1'b1);
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK);
  endtask
  // One encode period per sample keeps every serial mode inside its burst length
  task automatic send(input logic corner);
    logic [55:0] raw;
    int          n, tg, fc;
    logic        d0, f0;
    for (int c = 0; c < 4; c++) begin
      lfsr_q = lfsr_next(lfsr_q);
      raw[c*14 +: 14] = lfsr_q[13:0];
    end
    if (corner) raw = {14'h0000, 14'h1FFF, 14'h2000, 14'h3FFF};
    CONV_RESULT <= raw;
    ENC_CLK <= 1'b1;
    repeat (4) @(posedge CLK);
    ENC_CLK <= 1'b0;
    {n, tg, fc} = '0;
    {d0, f0} = {DATA_CLOCK_OUT, FRAME_MARKER};
    while (done !== 1'b1 && n < 60) begin
      @(posedge CLK);
      n++;
      tg += int'(DATA_CLOCK_OUT !== d0);
      fc += int'(FRAME_MARKER !== f0);
      {d0, f0} = {DATA_CLOCK_OUT, FRAME_MARKER};
    end
    if (!OUT_DRIVE_EN || CORE_SLEEP) check("dco toggles", 0, tg);
    else begin
      check("dco toggles", one_lane ? bits : bits / 2, tg);
      check("frame edges", (!one_lane && bits == 14) ? 1 : 2, fc);
      for (int c = 0; c < 4; c++) begin
        check("word", exp_word(raw[c*14 +: 14], c), word[c]);
        if (rnd && !tst && bits != 12 && nap == 0)
          check("decoded", raw[c*14 +: 14] ^ (twos ? 14'h2000 : 14'h0), clean[c]);
      end
      if (one_lane) check("lane b", 0, DATA_OUT_B);
    end
    repeat (3) @(posedge CLK);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {SYS_RST, WB_CYC_I, WB_STB_I, WB_WE_I, ENC_CLK, CONFIG_INTERFACE_SELECT} = 6'h20;
    {LANE_SEL_PIN, CURRENT_SEL_PIN, SLEEP_PIN, TERM_PIN, WB_ADR_I} = 8'h00;
    {WB_SEL_I, WB_DAT_I, CONV_RESULT} = {4'hF, 88'h0};
    {one_lane, twos, rnd, tst, nap, pat, bits} = {8'h00, 14'h0000, 5'h10};
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    wb(0, 4'h0, 0);
    check("power reg", 32'h00, rd);
    wb(0, 4'h4, 0);
    check("output reg", 32'h04, rd);
    wb(0, 4'hC, 0);
    check("status", 32'h4600, rd);
    wb(1, 4'h1, 32'hFF);
    wb(0, 4'h1, 0);
    check("unmapped", 32'h00, rd);
    check("current", 8'h46, DRIVE_CURRENT);
    $display("test registers done");
    for (int m = 0; m < 6; m++) begin
      one_lane = m >= 3;
      bits = 5'(16 - 2 * (m % 3));
      wb(1, 4'h4, 32'h04 | (32'(m % 3) << 6) | (32'(one_lane) << 5));
      send(1);
      send(0);
    end
    $display("test serial modes done");
    wb(1, 4'h4, 32'h04);
    {one_lane, bits} = {1'b0, 5'h10};
    for (int f = 0; f < 8; f++) begin
      {tst, rnd, twos} = 3'(f);
      pat = lfsr_q[13:0];
      wb(1, 4'h0, 32'(f[1:0]) << 5);
      wb(1, 4'h8, {16'h0000, f[2], 1'b0, pat});
      send(f == 0);
      send(0);
    end
    $display("test formats done");
    {tst, rnd, twos, nap} = 7'h05;
    wb(1, 4'h8, 0);
    wb(1, 4'h0, 32'h05);
    check("nap", 4'h5, CHANNEL_NAP);
    send(0);
    nap = 4'h0;
    wb(1, 4'h0, 32'h10);
    check("sleep", 1, CORE_SLEEP);
    send(0);
    wb(1, 4'h0, 32'h00);
    $display("test power down done");
    for (int k = 0; k < 11; k++) begin
      wb(1, 4'h4, 32'(k));
      repeat (2) @(posedge CLK);
      check("current", cur_of(4'(k)), DRIVE_CURRENT);
    end
    wb(1, 4'h4, 32'h14);
    repeat (2) @(posedge CLK);
    check("drive on", 0, OUT_DRIVE_EN);
    send(0);
    $display("test drive current done");
    CONFIG_INTERFACE_SELECT <= 1'b1;
    {LANE_SEL_PIN, CURRENT_SEL_PIN, TERM_PIN} <= 3'h7;
    repeat (8) @(posedge CLK);
    check("current", 8'h46, DRIVE_CURRENT);
    {one_lane, bits} = {1'b1, 5'h0E};
    send(1);
    {LANE_SEL_PIN, CURRENT_SEL_PIN, TERM_PIN} <= 3'h0;
    repeat (8) @(posedge CLK);
    check("current", 8'h46, DRIVE_CURRENT);
    SLEEP_PIN <= 1'b1;
    repeat (8) @(posedge CLK);
    check("sleep", 1, CORE_SLEEP);
    check("current", 0, DRIVE_CURRENT);
    SLEEP_PIN <= 1'b0;
    {one_lane, bits} = {1'b0, 5'h10};
    repeat (8) @(posedge CLK);
    send(0);
    $display("test pin mode done");
    finish_test;
  end
  initial begin
    #2000000;
    fail_count++;
    finish_test;
  end
endmodule
